// ===== rtl/pss_pkg.sv
// package for the phy status summary upper bank
package pss_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_STATUS_SUMMARY   = 8'h10;
    localparam logic [7:0] IDX_IRQ_STATUS       = 8'h12;
    localparam logic [7:0] IDX_FALSE_CARRIER    = 8'h14;
    localparam logic [7:0] IDX_RX_ERROR_COUNT   = 8'h15;
    localparam logic [7:0] IDX_PCS_CONFIG       = 8'h16;
    localparam logic [7:0] IDX_NEG_EXPANSION    = 8'h06;
    localparam logic [7:0] IDX_TENBASE_STATUS   = 8'h1A;
    // summary field positions
    localparam int         BIT_RESERVED15       = 15;
    localparam int         BIT_CROSSOVER        = 14;
    localparam int         BIT_RX_ERROR         = 13;
    localparam int         BIT_POLARITY         = 12;
    localparam int         BIT_FALSE_CARRIER    = 11;
    localparam int         BIT_SIGNAL_DETECT    = 10;
    localparam int         BIT_DESCRAMBLER_LOCK = 9;
    localparam int         BIT_PAGE_RECEIVED    = 8;
    localparam int         BIT_IRQ_PENDING      = 7;
    // fields in neighbouring registers
    localparam int         BIT_SD_QUALIFY       = 8;
    localparam int         BIT_TENBASE_POLARITY = 4;
    localparam int         BIT_NEG_PAGE_RX      = 1;
    // reset values
    localparam logic       RST_FLAG             = 1'b0;
    localparam logic       RST_SD_QUALIFY       = 1'b0;
    localparam logic [31:0] RST_PRDATA          = 32'h0000_0000;

    typedef struct packed {
        logic crossover_auto_enable;
        logic crossover_force;
        logic crossover_swapped;
    } pss_xover_t;

    typedef struct packed {
        logic rx_error;
        logic polarity_inverted;
        logic false_carrier;
        logic page_received;
        logic interrupt;
    } pss_events_t;

    typedef struct packed {
        logic        crossover;
        logic        rx_error;
        logic        polarity;
        logic        false_carrier;
        logic        sd_ll;
        logic        lock_ll;
        logic        page_rx;
        logic        irq;
        logic        sd_qualify;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic [15:0] status;
    } pss_state_t;
endpackage

// ===== rtl/pss_status_summary.sv
// phy status summary upper bits 15..7 behind an apb slave
//
// Design decision made here: the APB register port.
`timescale 1ns/1ns
module pss_status_summary #(
    parameter int ADDR_W = 8
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst,
    input  wire logic                 i_ce,
    input  wire logic                 i_psel,
    input  wire logic                 i_penable,
    input  wire logic                 i_pwrite,
    input  wire logic [ADDR_W-1:0]    i_paddr,
    input  wire logic [31:0]          i_pwdata,
    input  wire pss_pkg::pss_xover_t  i_xover,
    input  wire pss_pkg::pss_events_t i_events,
    input  wire logic                 i_signal_detect_raw,
    input  wire logic                 i_descrambler_lock,
    output logic                      o_pready,
    output logic                      o_pslverr,
    output logic [31:0]               o_prdata,
    output logic [15:0]               o_phy_status_summary
);
    import pss_pkg::*;

    if (ADDR_W < 7) begin : g_addr_check
        $error("ADDR_W too small for the register map");
    end

    pss_state_t s_reg;
    pss_state_t s_next;

    logic       done;
    logic       rd_done;
    logic       sd_qual;

    // word-aligned index match
    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        logic [ADDR_W-1:0] want;
        want = ADDR_W'({idx, 2'b00});
        return addr == want;
    endfunction

    function automatic logic [15:0] summary_word(input pss_state_t s);
        logic [15:0] w;
        w = 16'h0000;
        w[BIT_RESERVED15]       = 1'b0;
        w[BIT_CROSSOVER]        = s.crossover;
        w[BIT_RX_ERROR]         = s.rx_error;
        w[BIT_POLARITY]         = s.polarity;
        w[BIT_FALSE_CARRIER]    = s.false_carrier;
        w[BIT_SIGNAL_DETECT]    = s.sd_ll;
        w[BIT_DESCRAMBLER_LOCK] = s.lock_ll;
        w[BIT_PAGE_RECEIVED]    = s.page_rx;
        w[BIT_IRQ_PENDING]      = s.irq;
        return w;
    endfunction

    assign done    = i_psel & i_penable & s_reg.pready;
    assign rd_done = done & ~i_pwrite;
    assign sd_qual = i_signal_detect_raw & (~s_reg.sd_qualify | i_descrambler_lock);

    always_comb begin
        s_next = s_reg;
        // crossover state from force and auto-enable
        if (i_xover.crossover_force) begin
            s_next.crossover = 1'b1;
        end else if (i_xover.crossover_auto_enable) begin
            s_next.crossover = i_xover.crossover_swapped;
        end else begin
            s_next.crossover = 1'b0;
        end
        // latching-high flags, a new event wins over a clearing read
        s_next.rx_error = i_events.rx_error
                        | (s_reg.rx_error & ~(rd_done & hit(i_paddr, IDX_RX_ERROR_COUNT)));
        s_next.polarity = i_events.polarity_inverted
                        | (s_reg.polarity & ~(rd_done & hit(i_paddr, IDX_TENBASE_STATUS)));
        s_next.false_carrier = i_events.false_carrier
                        | (s_reg.false_carrier & ~(rd_done & hit(i_paddr, IDX_FALSE_CARRIER)));
        s_next.page_rx = i_events.page_received
                        | (s_reg.page_rx & ~(rd_done & hit(i_paddr, IDX_NEG_EXPANSION)));
        s_next.irq = i_events.interrupt
                        | (s_reg.irq & ~(rd_done & hit(i_paddr, IDX_IRQ_STATUS)));
        // latching-low: reload at a completed summary read, else hold any drop
        if (rd_done && hit(i_paddr, IDX_STATUS_SUMMARY)) begin
            s_next.sd_ll   = sd_qual;
            s_next.lock_ll = i_descrambler_lock;
        end else begin
            s_next.sd_ll   = s_reg.sd_ll & sd_qual;
            s_next.lock_ll = s_reg.lock_ll & i_descrambler_lock;
        end
        // the only writable control bit; summary writes are ignored
        if (done && i_pwrite && hit(i_paddr, IDX_PCS_CONFIG)) begin
            s_next.sd_qualify = i_pwdata[BIT_SD_QUALIFY];
        end
        // apb: answer in the cycle after setup
        s_next.pready  = i_psel & ~i_penable;
        s_next.pslverr = 1'b0;
        s_next.prdata  = RST_PRDATA;
        if (i_psel && !i_penable) begin
            if (hit(i_paddr, IDX_STATUS_SUMMARY)) begin
                s_next.prdata = {16'h0000, summary_word(s_reg)};
            end else if (hit(i_paddr, IDX_PCS_CONFIG)) begin
                s_next.prdata[BIT_SD_QUALIFY] = s_reg.sd_qualify;
            end else if (hit(i_paddr, IDX_TENBASE_STATUS)) begin
                s_next.prdata[BIT_TENBASE_POLARITY] = s_reg.polarity;
            end else if (hit(i_paddr, IDX_NEG_EXPANSION)) begin
                s_next.prdata[BIT_NEG_PAGE_RX] = s_reg.page_rx;
            end else if (hit(i_paddr, IDX_RX_ERROR_COUNT)) begin
                s_next.prdata = RST_PRDATA;
            end else if (hit(i_paddr, IDX_FALSE_CARRIER)) begin
                s_next.prdata = RST_PRDATA;
            end else if (hit(i_paddr, IDX_IRQ_STATUS)) begin
                s_next.prdata[0] = s_reg.irq;
            end else begin
                s_next.pslverr = 1'b1;
            end
        end
        s_next.status = summary_word(s_next);
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s_reg.crossover     <= RST_FLAG;
            s_reg.rx_error      <= RST_FLAG;
            s_reg.polarity      <= RST_FLAG;
            s_reg.false_carrier <= RST_FLAG;
            s_reg.sd_ll         <= RST_FLAG;
            s_reg.lock_ll       <= RST_FLAG;
            s_reg.page_rx       <= RST_FLAG;
            s_reg.irq           <= RST_FLAG;
            s_reg.sd_qualify    <= RST_SD_QUALIFY;
            s_reg.pready        <= 1'b0;
            s_reg.pslverr       <= 1'b0;
            s_reg.prdata        <= RST_PRDATA;
            s_reg.status        <= 16'h0000;
        end else if (i_ce) begin
            s_reg <= s_next;
        end
    end

    assign o_pready             = s_reg.pready;
    assign o_pslverr            = s_reg.pslverr;
    assign o_prdata             = s_reg.prdata;
    assign o_phy_status_summary = s_reg.status;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    property p_bit15_zero;
        (s_reg.pready && hit(i_paddr, IDX_STATUS_SUMMARY)) |-> !o_prdata[BIT_RESERVED15] && !o_phy_status_summary[15];
    endproperty
    a_bit15_zero: assert property (p_bit15_zero) else $error("bit 15 read as one");

    property p_summary_read;
        (i_ce && i_psel && !i_penable && hit(i_paddr, IDX_STATUS_SUMMARY))
            |=> o_pready && !o_pslverr && o_prdata[15:0] == $past(summary_word(s_reg));
    endproperty
    a_summary_read: assert property (p_summary_read) else $error("summary read data wrong");

    property p_cross_force;
        (i_ce && i_xover.crossover_force) |=> o_phy_status_summary[BIT_CROSSOVER];
    endproperty
    a_cross_force: assert property (p_cross_force) else $error("forced crossover not shown");

    property p_cross_auto;
        (i_ce && i_xover.crossover_auto_enable && !i_xover.crossover_force)
            |=> s_reg.crossover == $past(i_xover.crossover_swapped);
    endproperty
    a_cross_auto: assert property (p_cross_auto) else $error("crossover not tracking swaps");

    property p_rxerr_latch;
        (i_ce && i_events.rx_error) ##1 (!(i_ce && rd_done && hit(i_paddr, IDX_RX_ERROR_COUNT)))[*2]
            |=> s_reg.rx_error;
    endproperty
    a_rxerr_latch: assert property (p_rxerr_latch) else $error("receive error latch lost");

    property p_pol_summary_keep;
        (s_reg.polarity && i_ce && rd_done && hit(i_paddr, IDX_STATUS_SUMMARY)) |=> s_reg.polarity;
    endproperty
    a_pol_summary_keep: assert property (p_pol_summary_keep) else $error("polarity cleared by summary read");

    property p_fc_clear;
        (i_ce && rd_done && hit(i_paddr, IDX_FALSE_CARRIER) && !i_events.false_carrier) |=> !s_reg.false_carrier;
    endproperty
    a_fc_clear: assert property (p_fc_clear) else $error("false carrier not cleared");

    property p_sd_low_hold;
        (!s_reg.sd_ll) ##0 (!(i_ce && rd_done && hit(i_paddr, IDX_STATUS_SUMMARY)))[*3] |=> !s_reg.sd_ll;
    endproperty
    a_sd_low_hold: assert property (p_sd_low_hold) else $error("signal detect latch rose without read");

    property p_sd_qualify;
        (i_ce && rd_done && hit(i_paddr, IDX_STATUS_SUMMARY) && s_reg.sd_qualify && !i_descrambler_lock)
            |=> !s_reg.sd_ll;
    endproperty
    a_sd_qualify: assert property (p_sd_qualify) else $error("qualified detect ignores lock");

    property p_lock_low;
        (i_ce && !i_descrambler_lock) |=> !s_reg.lock_ll;
    endproperty
    a_lock_low: assert property (p_lock_low) else $error("lock latch missed a drop");

    property p_page_keep;
        (s_reg.page_rx && !(i_ce && rd_done && hit(i_paddr, IDX_NEG_EXPANSION))) |=> s_reg.page_rx;
    endproperty
    a_page_keep: assert property (p_page_keep) else $error("page received lost");

    property p_irq_clear;
        (i_ce && rd_done && hit(i_paddr, IDX_IRQ_STATUS) && !i_events.interrupt) |=> !o_phy_status_summary[BIT_IRQ_PENDING];
    endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("interrupt pending not cleared");

    property p_irq_set;
        (i_ce && i_events.interrupt) |=> o_phy_status_summary[BIT_IRQ_PENDING];
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("interrupt pending not shown");

    property p_fc_latch;
        (i_ce && i_events.false_carrier) |=> s_reg.false_carrier;
    endproperty
    a_fc_latch: assert property (p_fc_latch) else $error("false carrier not latched");

    property p_fc_keep_summary;
        (s_reg.false_carrier && i_ce && rd_done && hit(i_paddr, IDX_STATUS_SUMMARY)) |=> s_reg.false_carrier;
    endproperty
    a_fc_keep_summary: assert property (p_fc_keep_summary) else $error("false carrier cleared by summary read");

    property p_pol_set;
        (i_ce && i_events.polarity_inverted) |=> o_phy_status_summary[BIT_POLARITY];
    endproperty
    a_pol_set: assert property (p_pol_set) else $error("polarity not shown");

    property p_pol_clear;
        (i_ce && rd_done && hit(i_paddr, IDX_TENBASE_STATUS) && !i_events.polarity_inverted) |=> !s_reg.polarity;
    endproperty
    a_pol_clear: assert property (p_pol_clear) else $error("polarity not cleared");

    property p_rxerr_clear;
        (i_ce && rd_done && hit(i_paddr, IDX_RX_ERROR_COUNT) && !i_events.rx_error) |=> !s_reg.rx_error;
    endproperty
    a_rxerr_clear: assert property (p_rxerr_clear) else $error("receive error not cleared");

    property p_rxerr_keep_summary;
        (s_reg.rx_error && i_ce && rd_done && hit(i_paddr, IDX_STATUS_SUMMARY)) |=> s_reg.rx_error;
    endproperty
    a_rxerr_keep_summary: assert property (p_rxerr_keep_summary) else $error("receive error cleared by summary read");

    property p_set_wins;
        (i_ce && i_events.rx_error && rd_done && hit(i_paddr, IDX_RX_ERROR_COUNT)) |=> s_reg.rx_error;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost to clearing read");

    property p_page_set;
        (i_ce && i_events.page_received) |=> s_reg.page_rx;
    endproperty
    a_page_set: assert property (p_page_set) else $error("page received not latched");

    property p_page_clear;
        (i_ce && rd_done && hit(i_paddr, IDX_NEG_EXPANSION) && !i_events.page_received) |=> !s_reg.page_rx;
    endproperty
    a_page_clear: assert property (p_page_clear) else $error("page received not cleared");

    property p_cross_off;
        (i_ce && !i_xover.crossover_auto_enable && !i_xover.crossover_force) |=> !s_reg.crossover;
    endproperty
    a_cross_off: assert property (p_cross_off) else $error("crossover set without control");

    property p_unused_zero;
        o_phy_status_summary[6:0] == 7'h00 && !o_phy_status_summary[BIT_RESERVED15];
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("summary bit outside range set");

    property p_lock_reload;
        (i_ce && rd_done && hit(i_paddr, IDX_STATUS_SUMMARY) && i_descrambler_lock) |=> s_reg.lock_ll;
    endproperty
    a_lock_reload: assert property (p_lock_reload) else $error("lock latch not reloaded");

    property p_sd_drop;
        (i_ce && !i_signal_detect_raw) |=> !s_reg.sd_ll;
    endproperty
    a_sd_drop: assert property (p_sd_drop) else $error("signal detect latch missed a drop");

    property p_prdata_idle;
        (i_ce && !(i_psel && !i_penable)) |=> o_prdata == RST_PRDATA;
    endproperty
    a_prdata_idle: assert property (p_prdata_idle) else $error("read data outside access");

    property p_ce_freeze;
        (!i_ce) |=> $stable(s_reg);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while clock enable low");
endmodule

// ===== verif/tb_top.sv
// self-checking testbench for the phy status summary upper bank
`timescale 1ns/1ns
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_top;
    import pss_pkg::*;
    logic        i_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1;
    logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic [7:0]  i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0000_0000;
    pss_xover_t  i_xover = '0;
    pss_events_t i_events = '0;
    logic        i_signal_detect_raw = 1'b0, i_descrambler_lock = 1'b0;
    logic        o_pready, o_pslverr;
    logic [31:0] o_prdata, rd;
    logic [15:0] o_phy_status_summary;
    logic        er;
    int          n_errors = 0, samples_checked = 0;
    pss_status_summary #(.ADDR_W(8)) i_pss_status_summary (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .i_xover(i_xover), .i_events(i_events), .i_signal_detect_raw(i_signal_detect_raw),
        .i_descrambler_lock(i_descrambler_lock), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .o_prdata(o_prdata), .o_phy_status_summary(o_phy_status_summary));
    initial begin
        forever #20 i_clk = ~i_clk;
    end
    function automatic logic [7:0] ba(input logic [7:0] idx);
        return {idx[5:0], 2'b00};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // one apb transfer, then one idle edge so no signal is driven twice at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge i_clk);
        i_psel <= 1'b1; i_penable <= 1'b0; i_pwrite <= wr; i_paddr <= a; i_pwdata <= wd;
        @(posedge i_clk);
        i_penable <= 1'b1;
        // look at the answer once it has settled, take it 1 ns after the edge that raises pready, before the edge that completes the access
        for (k = 0; k < 50; k++) begin
            #1;
            if (o_pready === 1'b1) break;
            @(posedge i_clk);
        end
        if (k == 50) begin
            n_errors++;
            $display("ERROR pready expected 1 seen 0");
        end
        rd = o_prdata;
        er = o_pslverr;
        @(posedge i_clk);
        i_psel <= 1'b0; i_penable <= 1'b0;
        tick(1);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic t_reset_map();
        `CHK("summary_rst", 16'h0000, o_phy_status_summary)
        apb(1'b0, ba(IDX_STATUS_SUMMARY), 32'h0000_0000);
        `CHK("summary_rd", 32'h0000_0000, rd)
        `CHK("summary_err", 1'b0, er)
        apb(1'b1, ba(IDX_STATUS_SUMMARY), 32'hFFFF_FFFF);
        apb(1'b0, ba(IDX_STATUS_SUMMARY), 32'h0000_0000);
        `CHK("bit15", 1'b0, rd[BIT_RESERVED15])
        apb(1'b0, 8'h7C, 32'h0000_0000);
        `CHK("unmapped_err", 1'b1, er)
        `CHK("unmapped_data", 32'h0000_0000, rd)
    endtask
    task automatic t_crossover();
        logic [2:0] k;
        for (int j = 0; j < 8; j++) begin
            k = 3'(j);
            @(posedge i_clk);
            i_xover <= pss_xover_t'(k);
            tick(3);
            `CHK("crossover", k[1] | (k[2] & k[0]), o_phy_status_summary[BIT_CROSSOVER])
        end
        apb(1'b0, ba(IDX_STATUS_SUMMARY), 32'h0000_0000);
        `CHK("crossover_rd", 1'b1, rd[BIT_CROSSOVER])
    endtask
    task automatic t_latches();
        logic [4:0] ev [5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
        logic [7:0] cl [5] = '{IDX_RX_ERROR_COUNT, IDX_TENBASE_STATUS, IDX_FALSE_CARRIER,
                               IDX_NEG_EXPANSION, IDX_IRQ_STATUS};
        int         bp [5] = '{BIT_RX_ERROR, BIT_POLARITY, BIT_FALSE_CARRIER, BIT_PAGE_RECEIVED, BIT_IRQ_PENDING};
        for (int j = 0; j < 5; j++) begin
            @(posedge i_clk);
            i_events <= pss_events_t'(ev[j]);
            @(posedge i_clk);
            i_events <= '0;
            tick(2);
            `CHK("flag_set", 1'b1, o_phy_status_summary[bp[j]])
            apb(1'b0, ba(IDX_STATUS_SUMMARY), 32'h0000_0000);
            `CHK("flag_rd", 1'b1, rd[bp[j]])
            tick(2);
            `CHK("flag_held", 1'b1, o_phy_status_summary[bp[j]])
            apb(1'b0, ba(cl[j]), 32'h0000_0000);
            tick(2);
            `CHK("flag_clr", 1'b0, o_phy_status_summary[bp[j]])
        end
    endtask
    task automatic t_ce();
        @(posedge i_clk);
        i_ce <= 1'b0; i_events <= pss_events_t'(5'h04);
        @(posedge i_clk);
        i_events <= '0;
        tick(2);
        `CHK("ce_hold", 1'b0, o_phy_status_summary[BIT_FALSE_CARRIER])
        i_ce <= 1'b1;
        tick(2);
        `CHK("ce_run", 1'b0, o_phy_status_summary[BIT_FALSE_CARRIER])
    endtask
    task automatic t_detect();
        @(posedge i_clk);
        i_signal_detect_raw <= 1'b1; i_descrambler_lock <= 1'b1;
        apb(1'b0, ba(IDX_STATUS_SUMMARY), 32'h0000_0000);
        tick(2);
        `CHK("sd_up", 2'b11, o_phy_status_summary[10:9])
        i_signal_detect_raw <= 1'b0;
        tick(2);
        i_signal_detect_raw <= 1'b1;
        tick(3);
        `CHK("sd_ll", 2'b01, o_phy_status_summary[10:9])
        apb(1'b0, ba(IDX_STATUS_SUMMARY), 32'h0000_0000);
        tick(2);
        `CHK("sd_reload", 2'b11, o_phy_status_summary[10:9])
        apb(1'b1, ba(IDX_PCS_CONFIG), 32'h0000_0100);
        apb(1'b0, ba(IDX_PCS_CONFIG), 32'h0000_0000);
        `CHK("qualify_rd", 1'b1, rd[BIT_SD_QUALIFY])
        i_descrambler_lock <= 1'b0;
        tick(2);
        i_descrambler_lock <= 1'b1;
        tick(3);
        `CHK("lock_ll", 2'b00, o_phy_status_summary[10:9])
        apb(1'b0, ba(IDX_STATUS_SUMMARY), 32'h0000_0000);
        tick(2);
        `CHK("lock_reload", 2'b11, o_phy_status_summary[10:9])
        apb(1'b0, ba(IDX_STATUS_SUMMARY), 32'h0000_0000);
        `CHK("lock_rd", 2'b11, rd[10:9])
    endtask
    initial begin
        tick(12);
        i_rst <= 1'b0;
        tick(1);
        t_reset_map();
        t_crossover();
        t_latches();
        t_detect();
        t_ce();
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        n_errors++;
        stop_test();
    end
endmodule
